// *** core/pcr_top.sv ***
/*
  PLL settings and clock routing registers with primary port clock generation.
  Assumes all clock sources are sampled levels and a single-cycle register port.
*/
// Notes on behaviour
// - second PLL fraction joins three registers
// - input halver divides oscillator by two
// - receive mode ignores second output halver
// - receive mode automates first divider
// - user mode divides by divider and halver
// - master pin input or driven source
// - auxiliary pin tristate or driven source
// - converter clock source select codes
// - override bit enables programmed selects
// - frame rate code picks divide ratio
// - bit rate code picks bits per frame
// - receiver master enable bit
// - receiver master clock source field
// - transmitter master enable bit
`timescale 1ns/1ps
module pcr_top import pcr_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_W-1:0] reg_rdata,
  // clock sources
  input wire logic oscillator_clock,
  input wire logic first_pll_output_clock,
  input wire logic second_pll_output_clock,
  input wire logic adc_master_clock_pin,
  // master clock pin
  input wire logic master_pin_in,
  output logic master_pin_out,
  output logic master_pin_oe,
  // auxiliary clock pin
  output logic aux_clock_output_pin,
  output logic aux_clock_output_oe,
  // PLL settings
  output pcr_pll_cfg_s pll_cfg,
  output logic first_pll_ref,
  output logic second_pll_ref,
  // converter clocks
  output logic dac_clk,
  output logic adc_clk,
  output logic spdif_tx_clk,
  // primary audio port clocks
  output pcr_port_clk_s rx_port_clk,
  output pcr_port_clk_s tx_port_clk
);
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [REG_W-1:0] cfg_r [CFG_LO:CFG_HI];
  logic mode_r;
  logic [REG_W-1:0] status;

  function automatic logic is_cfg(logic [ADDR_W-1:0] a);
    return (a >= OFF_FIRST_PLL) && (a <= OFF_TX_PORT);
  endfunction : is_cfg

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = CFG_LO; i <= CFG_HI; i++) begin
        cfg_r[i] <= CFG_RESET[i-CFG_LO];
      end
    end else if (reg_wr && is_cfg(reg_addr)) begin
      cfg_r[reg_addr[3:0]] <= reg_wdata;
    end
  end

  // receive-mode flag: set while the S/PDIF receiver owns the PLLs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_MODE) begin
      mode_r <= reg_wdata[0];
    end
  end

  assign status = {5'h00, tx_port_clk.drive, rx_port_clk.drive, master_pin_oe,
                   aux_clock_output_oe};

  // read data stands for one cycle only, zero otherwise and for holes in the map
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (is_cfg(reg_addr)) begin
      reg_rdata <= cfg_r[reg_addr[3:0]];
    end else if (reg_addr == OFF_MODE) begin
      reg_rdata <= {8'h00, mode_r};
    end else if (reg_addr == OFF_STATUS) begin
      reg_rdata <= status;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // PLL settings
  // ----------------------------------------------------------------
  logic [FRAC_W-1:0] fraction;
  logic [REG_W-1:0] pll_a;
  logic [REG_W-1:0] pll_b;

  assign pll_a = cfg_r[OFF_FIRST_PLL[3:0]];
  assign pll_b = cfg_r[OFF_DIV_PINS[3:0]];
  assign fraction = {cfg_r[OFF_FRAC_HIGH_INT[3:0]][3:0], cfg_r[OFF_FRAC_MID[3:0]],
                     cfg_r[OFF_FRAC_LOW[3:0]]};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_cfg <= '0;
    end else begin
      pll_cfg.fraction <= fraction;
      pll_cfg.integer_part <= cfg_r[OFF_FRAC_HIGH_INT[3:0]][F_INT+:4];
      pll_cfg.first_in_halve <= pll_a[F_PRE];
      pll_cfg.second_in_halve <= pll_b[F_PRE];
      // in user mode each PLL divides by its divider and halver together
      pll_cfg.first_out_halve <= pll_a[F_POST];
      pll_cfg.second_out_halve <= mode_r ? 1'b0 : pll_b[F_POST];
      pll_cfg.first_div <= mode_r ? AUTO_DIV : pll_a[F_DIV+:2];
      pll_cfg.second_div <= mode_r ? 2'h0 : pll_b[F_DIV+:2];
    end
  end

  pcr_pll_ref u_ref_a (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .osc_level(oscillator_clock),
    .halve(pll_a[F_PRE]),
    .ref_out(first_pll_ref)
  );

  pcr_pll_ref u_ref_b (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .osc_level(oscillator_clock),
    .halve(pll_b[F_PRE]),
    .ref_out(second_pll_ref)
  );

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  logic [1:0] mpin_sel;
  logic [1:0] aux_sel;
  logic mpin_level;

  assign mpin_sel = pll_b[F_MPIN+:2];
  assign aux_sel = pll_b[F_AUX+:2];
  // while driven, the master pin carries our own output back into the selects
  assign mpin_level = (mpin_sel == SEL_OFF) ? master_pin_in : master_pin_out;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      master_pin_oe <= 1'b0;
      master_pin_out <= 1'b0;
    end else begin
      master_pin_oe <= (mpin_sel != SEL_OFF);
      master_pin_out <= src_mux(mpin_sel, 1'b0, first_pll_output_clock,
                                second_pll_output_clock, oscillator_clock);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aux_clock_output_oe <= 1'b0;
      aux_clock_output_pin <= 1'b0;
    end else begin
      aux_clock_output_oe <= (aux_sel != SEL_OFF);
      aux_clock_output_pin <= src_mux(aux_sel, 1'b0, first_pll_output_clock,
                                      second_pll_output_clock, oscillator_clock);
    end
  end

  // ----------------------------------------------------------------
  // converter clock selection
  // ----------------------------------------------------------------
  logic [REG_W-1:0] conv;
  logic manual;
  logic [1:0] dac_code;
  logic [1:0] adc_code;
  logic [1:0] tx_code;

  assign conv = cfg_r[OFF_CONV_SEL[3:0]];
  assign manual = conv[F_OVR];
  assign dac_code = manual ? conv[F_DAC+:2] : AUTO_DAC;
  assign adc_code = manual ? conv[F_ADC+:2] : AUTO_ADC;
  assign tx_code = manual ? conv[F_TX+:2] : AUTO_TX;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_clk <= 1'b0;
      adc_clk <= 1'b0;
      spdif_tx_clk <= 1'b0;
    end else begin
      dac_clk <= src_mux(dac_code, mpin_level, first_pll_output_clock,
                         second_pll_output_clock, mpin_level);
      adc_clk <= src_mux(adc_code, adc_master_clock_pin, first_pll_output_clock,
                         second_pll_output_clock, mpin_level);
      spdif_tx_clk <= src_mux(tx_code, adc_master_clock_pin, first_pll_output_clock,
                              second_pll_output_clock, mpin_level);
    end
  end

  // ----------------------------------------------------------------
  // primary audio port clocks
  // ----------------------------------------------------------------
  pcr_port_cfg_s rx_cfg;
  pcr_port_cfg_s tx_cfg;
  logic rx_src;
  logic tx_src;

  always_comb begin
    rx_cfg = pcr_port_cfg_s'(cfg_r[OFF_RX_PORT[3:0]][7:0]);
    tx_cfg = pcr_port_cfg_s'(cfg_r[OFF_TX_PORT[3:0]][7:0]);
    if (!manual) begin
      rx_cfg.src = AUTO_PORT;
      tx_cfg.src = AUTO_PORT;
    end
  end

  // the transmitter reuses the receiver's source encoding in the same bits
  assign rx_src = src_mux(rx_cfg.src, mpin_level, first_pll_output_clock,
                          second_pll_output_clock, mpin_level);
  assign tx_src = src_mux(tx_cfg.src, mpin_level, first_pll_output_clock,
                          second_pll_output_clock, mpin_level);

  pcr_frame_gen u_rx_gen (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg(rx_cfg),
    .src_level(rx_src),
    .port_clk(rx_port_clk)
  );

  pcr_frame_gen u_tx_gen (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cfg(tx_cfg),
    .src_level(tx_src),
    .port_clk(tx_port_clk)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  frac_join_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_wr && reg_addr == OFF_FRAC_MID ##1 !(reg_wr && reg_addr == OFF_FRAC_MID)
    |=> pll_cfg.fraction[17:9] == $past(reg_wdata, 2))
    else $error("fraction middle bits not taken from register");

  rx_halver_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(mode_r) |-> !pll_cfg.second_out_halve && pll_cfg.second_div == 2'h0)
    else $error("second PLL divider used in receive mode");

  auto_div_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(mode_r) |-> pll_cfg.first_div == AUTO_DIV)
    else $error("first divider not automatic in receive mode");

  user_div_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(reset_n) && !$past(mode_r) |-> pll_cfg.second_div == $past(pll_b[F_DIV+:2])
      && pll_cfg.second_out_halve == $past(pll_b[F_POST]))
    else $error("user mode division does not follow fields");

  mpin_dir_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mpin_sel == SEL_OSC ##1 mpin_sel == SEL_OSC |=> master_pin_oe
      && master_pin_out == $past(oscillator_clock))
    else $error("master pin not driven from oscillator");

  aux_tristate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    aux_sel == SEL_OFF |=> !aux_clock_output_oe && !aux_clock_output_pin)
    else $error("auxiliary pin driven while off");

  adc_select_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    manual && conv[F_ADC+:2] == SEL_PLL_B |=> adc_clk == $past(second_pll_output_clock))
    else $error("adc clock not from second PLL");

  auto_conf_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !manual |=> spdif_tx_clk == $past(first_pll_output_clock))
    else $error("auto configuration ignored");

  rx_master_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_cfg.master && rx_cfg.rate != 3'h7 [*2] |-> rx_port_clk.drive)
    else $error("receiver master mode not driving");

  tx_slave_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !tx_cfg.master |=> !tx_port_clk.drive)
    else $error("transmitter slave still drives");

  rx_source_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    manual && rx_cfg.src == SEL_PLL_A |-> rx_src == first_pll_output_clock)
    else $error("receiver source not first PLL");

  read_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

  rx_master_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    rx_port_clk.drive ##1 $rose(rx_port_clk.frame_clk));
  mode_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(mode_r) ##2 pll_cfg.first_div == AUTO_DIV);
  mpin_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    master_pin_oe && manual && dac_code == SEL_OSC);
endmodule : pcr_top

// *** core/pcr_pkg.sv ***
/*
  Shared constants, types and helpers for the PLL and clock routing block.
  Assumes every clock source is presented as a level that is sampled on ref_clk.
*/
package pcr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned REG_W = 9;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_FIRST_PLL = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_FRAC_LOW = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FRAC_MID = 8'h05;
  localparam logic [ADDR_W-1:0] OFF_FRAC_HIGH_INT = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_DIV_PINS = 8'h07;
  localparam logic [ADDR_W-1:0] OFF_CONV_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RX_PORT = 8'h09;
  localparam logic [ADDR_W-1:0] OFF_TX_PORT = 8'h0A;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h21;
  localparam int unsigned CFG_LO = 3;
  localparam int unsigned CFG_HI = 10;
  // reset values, indexed by offset minus CFG_LO
  localparam logic [7:0][REG_W-1:0] CFG_RESET = {
    9'h002, 9'h002, 9'h010, 9'h190, 9'h07D, 9'h17E, 9'h121, 9'h010};
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_PRE = 0;
  localparam int unsigned F_POST = 1;
  localparam int unsigned F_DIV = 3;
  localparam int unsigned F_MPIN = 5;
  localparam int unsigned F_AUX = 7;
  localparam int unsigned F_DAC = 0;
  localparam int unsigned F_ADC = 2;
  localparam int unsigned F_TX = 4;
  localparam int unsigned F_OVR = 6;
  localparam int unsigned F_INT = 4;
  localparam int unsigned FRAC_W = 22;
  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_PLL_A = 2'h1;
  localparam logic [1:0] SEL_PLL_B = 2'h2;
  localparam logic [1:0] SEL_OSC = 2'h3;
  localparam logic [1:0] AUTO_DIV = 2'h2;
  localparam logic [1:0] AUTO_DAC = 2'h0;
  localparam logic [1:0] AUTO_ADC = 2'h0;
  localparam logic [1:0] AUTO_TX = 2'h1;
  localparam logic [1:0] AUTO_PORT = 2'h0;
  localparam logic [1:0] BITS_SYS = 2'h3;

  typedef struct packed {
    logic [FRAC_W-1:0] fraction;
    logic [3:0] integer_part;
    logic first_in_halve;
    logic second_in_halve;
    logic first_out_halve;
    logic second_out_halve;
    logic [1:0] first_div;
    logic [1:0] second_div;
  } pcr_pll_cfg_s;

  // matches register bits 7:0 of either primary port register
  typedef struct packed {
    logic [1:0] src;
    logic master;
    logic [1:0] bits;
    logic [2:0] rate;
  } pcr_port_cfg_s;

  typedef struct packed {
    logic bit_clk;
    logic frame_clk;
    logic drive;
  } pcr_port_clk_s;

  // source clocks per frame; zero marks the unused code
  function automatic logic [10:0] frame_div(logic [2:0] rate);
    case (rate)
      3'h0: return 11'h080;
      3'h1: return 11'h0C0;
      3'h2: return 11'h100;
      3'h3: return 11'h180;
      3'h4: return 11'h200;
      3'h5: return 11'h300;
      3'h6: return 11'h480;
      default: return 11'h000;
    endcase
  endfunction : frame_div

  // twice the bit clocks per frame, i.e. bit clock edges per frame
  function automatic logic [7:0] bit_edges(logic [1:0] bits);
    case (bits)
      2'h0: return 8'h80;
      2'h1: return 8'h40;
      2'h2: return 8'h20;
      default: return 8'h00;
    endcase
  endfunction : bit_edges

  function automatic logic src_mux(logic [1:0] code, logic c0, logic c1, logic c2,
                                   logic c3);
    case (code)
      2'h0: return c0;
      2'h1: return c1;
      2'h2: return c2;
      default: return c3;
    endcase
  endfunction : src_mux
endpackage : pcr_pkg

// *** core/pcr_pll_ref.sv ***
/*
  PLL reference pre-scaler: passes the oscillator level or halves it.
  Assumes the oscillator is a sampled level well below half of ref_clk.
*/
`timescale 1ns/1ps
module pcr_pll_ref import pcr_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  input wire logic osc_level,
  input wire logic halve,
  // reference out
  output logic ref_out
);
  logic osc_prev_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_level;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_out <= 1'b0;
    end else if (!halve) begin
      ref_out <= osc_level;
    end else if (osc_level && !osc_prev_r) begin
      ref_out <= !ref_out;
    end
  end

  halved_toggle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    halve && $past(halve) && !(osc_level && !osc_prev_r) |=> $stable(ref_out))
    else $error("halved reference moved without an oscillator edge");
endmodule : pcr_pll_ref

// *** core/pcr_frame_gen.sv ***
/*
  Master-mode bit clock and frame clock generator for one primary port direction.
  Assumes the selected source is a sampled level with at most one rise per two cycles.
*/
`timescale 1ns/1ps
module pcr_frame_gen import pcr_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // configuration and source
  input wire pcr_port_cfg_s cfg,
  input wire logic src_level,
  // generated clocks
  output pcr_port_clk_s port_clk
);
  logic src_prev_r;
  logic [10:0] cnt_r;
  logic [11:0] acc_r;
  logic [10:0] div;
  logic [11:0] acc_sum;
  logic rise;
  logic run;

  assign div = frame_div(cfg.rate);
  assign rise = src_level && !src_prev_r;
  // the unused rate code leaves the clocks parked rather than guessing a ratio
  assign run = cfg.master && (div != 11'h000);
  assign acc_sum = acc_r + {4'h0, bit_edges(cfg.bits)};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_level;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 11'h000;
      acc_r <= 12'h000;
      port_clk <= '0;
    end else if (!run) begin
      cnt_r <= 11'h000;
      acc_r <= 12'h000;
      port_clk <= '0;
    end else begin
      port_clk.drive <= 1'b1;
      if (cfg.bits == BITS_SYS) begin
        port_clk.bit_clk <= src_level;
      end
      if (rise) begin
        cnt_r <= (cnt_r >= div - 11'h001) ? 11'h000 : cnt_r + 11'h001;
        port_clk.frame_clk <= (cnt_r < {1'b0, div[10:1]});
        if (cfg.bits != BITS_SYS) begin
          // accumulator spreads the bit edges evenly across the frame
          if (acc_sum >= {1'b0, div}) begin
            acc_r <= acc_sum - {1'b0, div};
            port_clk.bit_clk <= !port_clk.bit_clk;
          end else begin
            acc_r <= acc_sum;
          end
        end
      end
    end
  end

  sys_bit_clk_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    run && cfg.bits == BITS_SYS |=> port_clk.bit_clk == $past(src_level))
    else $error("bit clock does not follow the system clock");
  slave_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !cfg.master |=> !port_clk.drive && !port_clk.bit_clk)
    else $error("slave direction still drives its clocks");
endmodule : pcr_frame_gen

// *** test/tb_top.sv ***
/*
  Self-checking bench for the PLL and clock routing block: registers, routing, port clocks.
  Assumes the core/ package and modules are compiled first; sources are sampled levels.
*/
`timescale 1ns/1ps
module tb_top import pcr_pkg::*; ;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [REG_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic osc = 1'b0;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic adcp = 1'b0;
  logic mpin = 1'b0;
  logic run = 1'b0;
  logic [4:0] lv = '0;
  int cyc = 0;
  logic [31:0] seed = 32'h29E1;
  logic [REG_W-1:0] reg_rdata;
  logic mp_out, mp_oe, aux_pin, aux_oe, ref_a, ref_b, dac_clk, adc_clk, tx_clk;
  pcr_pll_cfg_s pll_cfg;
  pcr_port_clk_s rx_port_clk, tx_port_clk;
  int n_errors = 0;
  int comparisons = 0;
  int per;
  int nb;
  int fd [7] = '{128, 192, 256, 384, 512, 768, 1152};

  pcr_top i_dut (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .oscillator_clock(osc), .first_pll_output_clock(pa), .second_pll_output_clock(pb),
    .adc_master_clock_pin(adcp), .master_pin_in(mpin), .master_pin_out(mp_out),
    .master_pin_oe(mp_oe), .aux_clock_output_pin(aux_pin), .aux_clock_output_oe(aux_oe),
    .pll_cfg, .first_pll_ref(ref_a), .second_pll_ref(ref_b), .dac_clk, .adc_clk,
    .spdif_tx_clk(tx_clk), .rx_port_clk, .tx_port_clk
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // distinct source periods, so a wrong source pick shows as a wrong frame length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (run) begin
      {osc, pa, pb, mpin} <= {cyc % 8 < 4, cyc % 4 < 2, cyc % 6 < 3, cyc % 10 < 5};
    end else begin
      // random levels from the sequence, so every source has a single driver
      {osc, pa, pb, adcp, mpin} <= lv;
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // codes 0 and 3 mean different sources for different outputs
  function automatic logic pick(logic [1:0] c, logic l0, logic l3);
    return (c == 2'h1) ? pa : (c == 2'h2) ? pb : (c == 2'h0) ? l0 : l3;
  endfunction : pick

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // one write or one read; a read compares the data of the following cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [8:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1;
    if (!w) check(reg_rdata, d);
  endtask : access

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic new_levels();
    @(posedge ref_clk);
    seed = lfsr(seed);
    lv <= seed[4:0];
  endtask : new_levels

  // cycles and bit clock rises between two frame clock rises
  task automatic meas(input logic t);
    int k;
    logic [1:0] pv;
    pcr_port_clk_s p;
    per = 0;
    nb = 0;
    k = 0;
    pv = 2'h3;
    for (int i = 0; i < 30000 && k < 2; i++) begin
      @(posedge ref_clk);
      #1;
      p = t ? tx_port_clk : rx_port_clk;
      k += p.frame_clk && !pv[1];
      per += k == 1;
      nb += k == 1 && p.bit_clk && !pv[0];
      pv = {p.frame_clk, p.bit_clk};
    end
    if (k < 2) begin
      n_errors++;
      complete_run();
    end
  endtask : meas

  // both directions to slave first, so counters start clean
  task automatic port_on(input logic t, input logic [8:0] d);
    access(1'b1, OFF_RX_PORT, 9'h000);
    access(1'b1, OFF_TX_PORT, 9'h000);
    access(1'b1, t ? OFF_TX_PORT : OFF_RX_PORT, d);
    meas(t);
    check({rx_port_clk.drive, tx_port_clk.drive}, {!t, t});
  endtask : port_on
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] c;
    logic [8:0] d;
    logic [5:0] f;
    logic [2:0] pv;
    logic [2:0] cur;
    int rc [3];
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = CFG_LO; a <= CFG_HI; a++) access(1'b0, a[7:0], CFG_RESET[a - CFG_LO]);
    @(posedge ref_clk);
    #1;
    check(reg_rdata, 9'h000);
    access(1'b0, OFF_STATUS, 9'h001);
    access(1'b1, 8'h30, 9'h1FF);
    access(1'b0, 8'h30, 9'h000);
    for (int n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      seed[25:22] = 4'h5 + {1'b0, seed[24:22]};
      access(1'b1, OFF_FRAC_LOW, seed[8:0]);
      access(1'b1, OFF_FRAC_MID, seed[17:9]);
      access(1'b1, OFF_FRAC_HIGH_INT, seed[26:18]);
      settle();
      check(pll_cfg.fraction, seed[21:0]);
      check(pll_cfg.integer_part, seed[25:22]);
      access(1'b0, OFF_FRAC_HIGH_INT, seed[26:18]);
    end
    for (int m = 0; m < 2; m++) begin
      seed = lfsr(seed);
      if (m) seed[9] = seed[0];
      if (m) access(1'b1, OFF_FRAC_HIGH_INT, 9'h07D);
      access(1'b1, OFF_MODE, m[8:0]);
      access(1'b0, OFF_MODE, m[8:0]);
      access(1'b1, OFF_FIRST_PLL, seed[8:0]);
      access(1'b1, OFF_DIV_PINS, {4'hC, seed[13:9]});
      settle();
      d[5:0] = m ? {AUTO_DIV, seed[1], 3'h0} : {seed[4:3], seed[1], seed[13:12], seed[10]};
      f = {pll_cfg.first_div, pll_cfg.first_out_halve, pll_cfg.second_div, pll_cfg.second_out_halve};
      check(f, d[5:0]);
      check({pll_cfg.first_in_halve, pll_cfg.second_in_halve}, {seed[0], seed[9]});
    end
    access(1'b1, OFF_MODE, 9'h000);
    access(1'b1, OFF_FIRST_PLL, 9'h000);
    access(1'b1, OFF_DIV_PINS, 9'h001);
    run <= 1'b1;
    pv = 3'h7;
    rc = '{0, 0, 0};
    repeat (160) begin
      @(posedge ref_clk);
      #1;
      cur = {osc, ref_a, ref_b};
      for (int j = 0; j < 3; j++) rc[j] += cur[j] && !pv[j];
      pv = cur;
    end
    check((rc[1] - rc[2]) ** 2 <= 1 && (2 * rc[0] - rc[2]) ** 2 <= 4, 1'b1);
    run <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      c = k[1:0];
      access(1'b1, k < 4 ? OFF_DIV_PINS : OFF_CONV_SEL, k < 4 ? {c, c, 5'h00} : {2'h0, k[3], c, c, c});
      new_levels();
      settle();
      cur = {pick(c, mpin, mpin), pick(c, adcp, mpin), pick(c, adcp, mpin)};
      if (k < 8) cur = {mpin, adcp, pa};
      if (k < 4) check({mp_oe, aux_oe, aux_pin}, {c != 0, c != 0, pick(c, 1'b0, osc)});
      if (k < 4 && c != 0) check(mp_out, pick(c, 1'b0, osc));
      if (k == 3) access(1'b1, OFF_DIV_PINS, 9'h000);
      if (k > 3) check({dac_clk, adc_clk, tx_clk}, cur);
    end
    run <= 1'b1;
    access(1'b1, OFF_RX_PORT, 9'h027);
    settle();
    check(rx_port_clk, 3'h0);
    for (int r = 0; r < 7; r++) begin
      port_on(r[0], {4'h3, 2'h0, r[2:0]});
      check(per, 4 * fd[r]);
      check(nb, 64);
    end
    for (int j = 0; j < 8; j++) begin
      c = j[1:0];
      d = {1'b0, c, 1'b1, ((c == 2'h3) ? 2'h0 : c), 3'h0};
      port_on(j > 3, d);
      check(per, 128 * (c == 2'h1 ? 4 : c == 2'h2 ? 6 : 10));
      check(nb, 64 >> d[4:3]);
    end
    port_on(1'b0, 9'h078);
    for (int i = 0; i < 8; i++) begin
      pv[0] = pa;
      @(posedge ref_clk);
      #1;
      check(rx_port_clk.bit_clk, pv[0]);
    end
    complete_run();
  end
endmodule : tb_top
